// file: input_port_pkg.sv
// constants and types for the host control and input port block
// assumes a 100 MHz system clock and one synchronous active high reset
package input_port_pkg;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_HZ        = 100_000_000;
    localparam int MASTER_HZ     = 3_686_400;
    localparam int SAMPLE_DIV    = 96;
    localparam int SAMPLE_HZ     = MASTER_HZ / SAMPLE_DIV;
    localparam int SAMPLE_CYCLES = CLK_HZ / SAMPLE_HZ;

    // ------------------------------------------------------------
    // widths
    // ------------------------------------------------------------
    localparam int INPUT_BITS     = 6;
    localparam int CHANGE_BITS    = 4;
    localparam int IRQ_BITS       = 8;
    localparam int IRQ_CHANGE_BIT = 7;
    localparam int UPPER_OUT_BITS = 5;

    // ------------------------------------------------------------
    // register select codes
    // ------------------------------------------------------------
    localparam logic [3:0] SEL_CHANGE      = 4'h4;
    localparam logic [3:0] SEL_STATUS_MASK = 4'h5;
    localparam logic [3:0] SEL_VECTOR      = 4'hc;
    localparam logic [3:0] SEL_INPUTS      = 4'hd;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] VECTOR_RESET = 8'h0f;
    localparam logic [7:0] MASK_RESET   = 8'h00;
    localparam logic [7:0] DATA_RESET   = 8'h00;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_ACK  = 2'b10
    } bus_state_e;

endpackage : input_port_pkg

// file: input_change_detect.sv
// synchroniser, sampling tick and two-sample level recogniser per pin
// assumes pins may change at any time relative to clk
`timescale 1ns/1ns
module input_change_detect
    import input_port_pkg::*;
#(
    parameter int WIDTH       = INPUT_BITS,
    parameter int TICK_CYCLES = SAMPLE_CYCLES
) (
    input  wire logic             clk,
    input  wire logic             reset,
    input  wire logic             clockEnable,
    input  wire logic [WIDTH-1:0] pins,
    output logic      [WIDTH-1:0] syncLevel,
    output logic      [WIDTH-1:0] changePulse
);
    import input_port_pkg::*;

    localparam int CW = $clog2(TICK_CYCLES);
    localparam logic [CW-1:0] TICK_LAST = CW'(TICK_CYCLES - 1);

    logic [WIDTH-1:0] sync1_reg,  sync1_next;
    logic [WIDTH-1:0] sync2_reg,  sync2_next;
    logic [WIDTH-1:0] sample_reg, sample_next;
    logic [WIDTH-1:0] stable_reg, stable_next;
    logic [WIDTH-1:0] pulse_reg,  pulse_next;
    logic [CW-1:0]    count_reg,  count_next;
    logic             primed_reg, primed_next;
    logic             tick;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        sync1_next  = pins;
        sync2_next  = sync1_reg;
        tick        = (count_reg == TICK_LAST);
        count_next  = tick ? '0 : count_reg + CW'(1);
        sample_next = sample_reg;
        stable_next = stable_reg;
        pulse_next  = '0;
        primed_next = primed_reg;
        if (tick) begin
            sample_next = sync2_reg;
            if (!primed_reg) begin
                // first tick after reset adopts levels silently
                stable_next = sync2_reg;
                primed_next = 1'b1;
            end else begin
                for (int i = 0; i < WIDTH; i++) begin
                    // new level seen on two ticks in a row
                    if (sync2_reg[i] == sample_reg[i] &&
                        sync2_reg[i] != stable_reg[i]) begin
                        stable_next[i] = sync2_reg[i];
                        pulse_next[i]  = 1'b1;
                    end
                end
            end
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (reset) begin
            sync1_reg  <= '0;
            sync2_reg  <= '0;
            sample_reg <= '0;
            stable_reg <= '0;
            pulse_reg  <= '0;
            count_reg  <= '0;
            primed_reg <= 1'b0;
        end else if (clockEnable) begin
            sync1_reg  <= sync1_next;
            sync2_reg  <= sync2_next;
            sample_reg <= sample_next;
            stable_reg <= stable_next;
            pulse_reg  <= pulse_next;
            count_reg  <= count_next;
            primed_reg <= primed_next;
        end
    end

    assign syncLevel   = sync2_reg;
    assign changePulse = pulse_reg;

endmodule : input_change_detect

// file: host_input_port.sv
// host bus control, interrupt request/vector and parallel input port
// assumes host strobes synchronous to clk; other events arrive as levels
`timescale 1ns/1ns
module host_input_port
    import input_port_pkg::*;
#(
    parameter int TICK_CYCLES = SAMPLE_CYCLES
) (
    input  wire logic                      clk,
    input  wire logic                      reset,
    input  wire logic                      clockEnable,
    input  wire logic                      chipSelectN,
    input  wire logic                      readWriteN,
    input  wire logic [3:0]                registerSelect,
    input  wire logic [7:0]                hostDataIn,
    output logic      [7:0]                hostDataOut,
    output logic                           hostDataOe,
    output logic                           transferAckN,
    output logic                           transferAckOe,
    input  wire logic                      interruptAckN,
    output logic                           irqN,
    output logic                           irqOe,
    input  wire logic [IRQ_BITS-1:0]       irqEvents,
    input  wire logic [CHANGE_BITS-1:0]    changeIrqEnable,
    input  wire logic [INPUT_BITS-1:0]     parallelInputs,
    output logic      [INPUT_BITS-1:0]     auxInputs,
    input  wire logic [UPPER_OUT_BITS-1:0] upperRouteIrq,
    input  wire logic [UPPER_OUT_BITS-1:0] discreteIrqN,
    input  wire logic [UPPER_OUT_BITS-1:0] generalOutputs,
    output logic      [UPPER_OUT_BITS-1:0] upperParallelOutputs
);
    import input_port_pkg::*;

    bus_state_e                state_reg,  state_next;
    logic [7:0]                data_reg,   data_next;
    logic                      drive_reg,  drive_next;
    logic [7:0]                mask_reg,   mask_next;
    logic [7:0]                vector_reg, vector_next;
    logic [CHANGE_BITS-1:0]    change_reg, change_next;
    logic [UPPER_OUT_BITS-1:0] upper_reg,  upper_next;
    logic [INPUT_BITS-1:0]     syncLevel;
    logic [INPUT_BITS-1:0]     changePulse;
    logic [IRQ_BITS-1:0]       status;
    logic                      pending;
    logic                      hostCycle;
    logic                      ackCycle;
    logic                      clearChange;

    // ------------------------------------------------------------
    // change detectors
    // ------------------------------------------------------------
    input_change_detect #(
        .WIDTH       (INPUT_BITS),
        .TICK_CYCLES (TICK_CYCLES)
    ) detect (
        .clk         (clk),
        .reset       (reset),
        .clockEnable (clockEnable),
        .pins        (parallelInputs),
        .syncLevel   (syncLevel),
        .changePulse (changePulse)
    );

    // ------------------------------------------------------------
    // interrupt status
    // ------------------------------------------------------------
    always_comb begin
        status = irqEvents;
        status[IRQ_CHANGE_BIT] = |(change_reg & changeIrqEnable);
        pending = |(status & mask_reg);
    end

    // ------------------------------------------------------------
    // bus cycle next state
    // ------------------------------------------------------------
    always_comb begin
        state_next  = state_reg;
        data_next   = data_reg;
        drive_next  = drive_reg;
        mask_next   = mask_reg;
        vector_next = vector_reg;
        clearChange = 1'b0;
        hostCycle   = !chipSelectN;
        ackCycle    = !interruptAckN && pending;
        case (state_reg)
            BUS_IDLE: begin
                if (hostCycle && readWriteN) begin
                    state_next = BUS_ACK;
                    drive_next = 1'b1;
                    case (registerSelect)
                        SEL_CHANGE: begin
                            data_next   = {change_reg,
                                           syncLevel[CHANGE_BITS-1:0]};
                            clearChange = 1'b1;
                        end
                        SEL_STATUS_MASK: data_next = status;
                        SEL_VECTOR:      data_next = vector_reg;
                        SEL_INPUTS:      data_next = {1'b1, interruptAckN,
                                             parallelInputs};
                        default:         data_next = 8'h00;
                    endcase
                end else if (hostCycle) begin
                    state_next = BUS_ACK;
                    drive_next = 1'b0;
                    case (registerSelect)
                        SEL_STATUS_MASK: mask_next   = hostDataIn;
                        SEL_VECTOR:      vector_next = hostDataIn;
                        default:         mask_next   = mask_reg;
                    endcase
                end else if (ackCycle) begin
                    state_next = BUS_ACK;
                    drive_next = 1'b1;
                    data_next  = vector_reg;
                end
            end
            BUS_ACK: begin
                // hold until the host ends the cycle
                if (chipSelectN && interruptAckN) begin
                    state_next = BUS_IDLE;
                    drive_next = 1'b0;
                end
            end
            default: begin
                state_next = BUS_IDLE;
                drive_next = 1'b0;
            end
        endcase
        // new events win over the read clear
        change_next = (clearChange ? '0 : change_reg)
                    | changePulse[CHANGE_BITS-1:0];
        upper_next = (upperRouteIrq & discreteIrqN)
                   | (~upperRouteIrq & generalOutputs);
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (reset) begin
            state_reg  <= BUS_IDLE;
            data_reg   <= DATA_RESET;
            drive_reg  <= 1'b0;
            mask_reg   <= MASK_RESET;
            vector_reg <= VECTOR_RESET;
            change_reg <= '0;
            upper_reg  <= '1;
        end else if (clockEnable) begin
            state_reg  <= state_next;
            data_reg   <= data_next;
            drive_reg  <= drive_next;
            mask_reg   <= mask_next;
            vector_reg <= vector_next;
            change_reg <= change_next;
            upper_reg  <= upper_next;
        end
    end

    // ------------------------------------------------------------
    // pins
    // ------------------------------------------------------------
    assign hostDataOut   = data_reg;
    assign hostDataOe    = drive_reg && (state_reg == BUS_ACK)
                         && (!chipSelectN || !interruptAckN);
    assign transferAckOe = (state_reg == BUS_ACK);
    assign transferAckN  = !(state_reg == BUS_ACK);
    assign irqOe         = pending;
    assign irqN          = !pending;
    assign auxInputs     = syncLevel;
    assign upperParallelOutputs = upper_reg;

endmodule : host_input_port

// file: host_input_port_monitor.sv
// concurrent checks on the ports of host_input_port
// assumes one clock and a synchronous active high reset; bound from bench
`timescale 1ns/1ns
module host_input_port_monitor
    import input_port_pkg::*;
(
    input wire logic                      clk,
    input wire logic                      reset,
    input wire logic                      chipSelectN,
    input wire logic                      interruptAckN,
    input wire logic [IRQ_BITS-1:0]       irqEvents,
    input wire logic [CHANGE_BITS-1:0]    changeIrqEnable,
    input wire logic                      hostDataOe,
    input wire logic                      transferAckN,
    input wire logic                      transferAckOe,
    input wire logic                      irqN,
    input wire logic                      irqOe,
    input wire logic [UPPER_OUT_BITS-1:0] upperRouteIrq,
    input wire logic [UPPER_OUT_BITS-1:0] discreteIrqN,
    input wire logic [UPPER_OUT_BITS-1:0] generalOutputs,
    input wire logic [UPPER_OUT_BITS-1:0] upperParallelOutputs
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (reset);
    chk_bus_release: assert property (
        hostDataOe |-> !transferAckN && !(chipSelectN && interruptAckN))
        else $error("bus driven when idle");
    chk_ack_latency: assert property (
        $fell(chipSelectN) && transferAckN |=> !transferAckN)
        else $error("ack late after select");
    chk_ack_stands: assert property (
        !transferAckN && !(chipSelectN && interruptAckN) |=> !transferAckN)
        else $error("ack lost");
    chk_ack_drops: assert property (
        !transferAckN && chipSelectN && interruptAckN |=> transferAckN)
        else $error("ack held after release");
    chk_irq_quiet: assert property (
        irqEvents == 8'h00 && changeIrqEnable == 4'h0 |-> irqN)
        else $error("irq without event");
    chk_interrupt_ack_n_ignored: assert property (
        irqN && transferAckN && chipSelectN && !interruptAckN
        |=> transferAckN) else $error("interrupt_ack_n taken");
    chk_upper_mux: assert property (
        !$past(reset) |-> upperParallelOutputs ==
        $past((upperRouteIrq & discreteIrqN) |
              (~upperRouteIrq & generalOutputs)))
        else $error("upper output wrong");
    chk_reset_quiet: assert property (
        $past(reset) |-> irqN && transferAckN)
        else $error("not quiet after reset");
    chk_ack_enable: assert property (
        transferAckOe == !transferAckN) else $error("ack enable wrong");
    chk_irq_enable: assert property (
        irqOe == !irqN) else $error("irq enable wrong");
    cover property ($fell(transferAckN) && !interruptAckN);
    cover property ($fell(transferAckN) && !chipSelectN);
    cover property ($fell(irqN));
endmodule : host_input_port_monitor

// file: host_bus_model.sv
// host processor model: register cycles and interrupt acknowledge cycles
// assumes the block answers on transferAckN within 20 clocks
`timescale 1ns/1ns
module host_bus_model (
    input  wire logic       clk,
    input  wire logic       transferAckN,
    input  wire logic [7:0] hostDataOut,
    input  wire logic       hostDataOe,
    output logic            chipSelectN = 1'b1,
    output logic            readWriteN = 1'b1,
    output logic      [3:0] registerSelect = 4'h0,
    output logic      [7:0] hostDataIn = 8'h00,
    output logic            interruptAckN = 1'b1
);
    task automatic cycle(input logic interrupt_ack_n, input logic rw,
        input logic [3:0] sel, input logic [7:0] wd, input int hold,
        output logic [7:0] rd, output logic got);
        @(posedge clk);
        #1;
        readWriteN = rw;
        registerSelect = sel;
        hostDataIn = wd;
        chipSelectN = interrupt_ack_n;
        interruptAckN = !interrupt_ack_n;
        got = 1'b0;
        repeat (20) if (!got) begin
            @(posedge clk);
            got = (transferAckN === 1'b0);
        end
        rd = hostDataOe ? hostDataOut : ~hostDataOut;
        repeat (hold) @(posedge clk);
        #1;
        chipSelectN = 1'b1;
        interruptAckN = 1'b1;
        // released bus: no stale value left on it
        hostDataIn = ~wd;
        repeat (2) @(posedge clk);
        #1;
    endtask : cycle
endmodule : host_bus_model

// file: host_input_port_test.sv
// self-checking bench for host_input_port driven through a host model
// assumes one 100 MHz clock; bench inputs change 1 ns after each edge
`timescale 1ns/1ns
module host_input_port_test;
    import input_port_pkg::*;
    localparam int TICK = 8;
    logic       clk, chipSelectN, readWriteN, interruptAckN, hostDataOe, g;
    logic       reset = 1'b1;
    logic       transferAckN, transferAckOe, irqN, irqOe;
    logic [3:0] registerSelect;
    logic [3:0] changeIrqEnable = 4'h0;
    logic [7:0] hostDataIn, hostDataOut, d;
    logic [7:0] irqEvents = 8'h00;
    logic [5:0] auxInputs;
    logic [5:0] parallelInputs = 6'h00;
    logic [4:0] upperParallelOutputs;
    logic [4:0] upperRouteIrq = 5'h15, discreteIrqN = 5'h0a;
    logic [4:0] generalOutputs = 5'h1c;
    int         errors = 0, nTests = 0;
    host_input_port #(.TICK_CYCLES(TICK)) i_host_input_port (
        .clk, .reset, .clockEnable(1'b1), .chipSelectN, .readWriteN,
        .registerSelect, .hostDataIn, .hostDataOut, .hostDataOe,
        .transferAckN, .transferAckOe, .interruptAckN, .irqN, .irqOe,
        .irqEvents, .changeIrqEnable, .parallelInputs, .auxInputs,
        .upperRouteIrq, .discreteIrqN, .generalOutputs, .upperParallelOutputs);
    host_bus_model i_host_bus_model (.clk, .transferAckN, .hostDataOut,
        .hostDataOe, .chipSelectN, .readWriteN, .registerSelect, .hostDataIn,
        .interruptAckN);
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        nTests++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : step
    task automatic bus(input logic rw, input logic [3:0] sel,
        input logic [7:0] w);
        i_host_bus_model.cycle(1'b0, rw, sel, w, int'(sel[0]), d, g);
        check({7'h00, g}, 8'h01);
    endtask : bus
    task automatic test_irq();
        bus(1'b1, SEL_VECTOR, 8'h00);
        check(d, VECTOR_RESET);
        bus(1'b0, SEL_STATUS_MASK, 8'h02);
        bus(1'b0, SEL_VECTOR, 8'ha5);
        irqEvents = 8'h03;
        step(1);
        check({7'h00, irqN}, 8'h00);
        bus(1'b1, SEL_STATUS_MASK, 8'h00);
        check(d, 8'h03);
        i_host_bus_model.cycle(1'b1, 1'b1, 4'h0, 8'h00, 2, d, g);
        check(d, 8'ha5);
        check({7'h00, g}, 8'h01);
        irqEvents = 8'h01;
        i_host_bus_model.cycle(1'b1, 1'b1, 4'h0, 8'h00, 0, d, g);
        check({7'h00, g}, 8'h00);
        bus(1'b1, 4'h0, 8'h00);
        check(d, 8'h00);
        $display("test irq done");
    endtask : test_irq
    task automatic test_ports();
        parallelInputs = 6'h2a;
        step(3);
        check({2'b00, auxInputs}, 8'h2a);
        check({3'b000, upperParallelOutputs}, 8'h08);
        bus(1'b1, SEL_INPUTS, 8'h00);
        check(d, 8'hea);
        $display("test ports done");
    endtask : test_ports
    task automatic test_change();
        changeIrqEnable = 4'h1;
        step(3 * TICK);
        bus(1'b1, SEL_CHANGE, 8'h00);
        check(d, 8'haa);
        bus(1'b0, SEL_STATUS_MASK, 8'h80);
        parallelInputs = 6'h2b;
        bus(1'b1, SEL_CHANGE, 8'h00);
        check(d & 8'hf0, 8'h00);
        step(2 * TICK + 6);
        check({7'h00, irqN}, 8'h00);
        bus(1'b1, SEL_CHANGE, 8'h00);
        check(d, 8'h1b);
        check({7'h00, irqN}, 8'h01);
        parallelInputs = 6'h2f;
        step(4);
        parallelInputs = 6'h2b;
        step(3 * TICK);
        bus(1'b1, SEL_CHANGE, 8'h00);
        check(d, 8'h0b);
        $display("test change done");
    endtask : test_change
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", nTests, errors);
        if (errors == 0 && nTests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : end_of_test
    initial begin
        step(10);
        reset = 1'b0;
        test_irq();
        test_ports();
        test_change();
        end_of_test();
    end
    initial begin
        #20000;
        errors++;
        end_of_test();
    end
endmodule : host_input_port_test
bind host_input_port host_input_port_monitor i_host_input_port_monitor (
    .clk, .reset, .chipSelectN, .interruptAckN, .irqEvents, .changeIrqEnable,
    .hostDataOe, .transferAckN, .transferAckOe, .irqN, .irqOe,
    .upperRouteIrq, .discreteIrqN,
    .generalOutputs, .upperParallelOutputs);
